// ==== verilog/twb_engine.sv ====
// Operation
// R01 - Start is data falling while clock high, sent or seen.
// R02 - Start trigger drives a start only when stop flag is set; the code also drives one from a master wait with the stop flag clear.
// R03 - Detected start sets the start-detected flag.
// R04 - Slave matches 7-bit address to own address, stays selected.
// R05 - Address byte goes out from shift register; received lands there.
// R06 - Direction bit 0 means master writes, 1 means master reads.
// R07 - Receiver pulls data low on ninth clock; sender samples it.
// R08 - Sender records returned acknowledge in ack-detected flag.
// R09 - Ack enable set acknowledges received bytes; clear leaves line.
// R10 - Transmit-mode flag updates on eighth address bit; 0 receiving.
// R11 - Receiving master omits last ack when ack enable is clear.
// R12 - Own address always acknowledged; foreign address never.
// R13 - Eight-clock wait: ack at eighth fall if enabled before release.
// R14 - Nine-clock wait: ack only if enabled beforehand.
// R15 - Stop is data rising while clock high, sent or seen.
// R16 - Stop trigger drives a stop condition.
// R17 - Detected stop sets stop flag; interrupt only if enabled.
// R18 - Master clocks; slave may stretch low; master waits for release.
// R19 - Wait holds clock low after start and after eighth or ninth clock.
// R20 - Shift write, wait release, or master start/stop ends a wait.
// R21 - Software performs one release action per wait.
// R22 - Disable or communication exit abandons transfer, drops wait.
// R23 - Both lines open drain: drive low or release, read wired level.
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module twb_engine
    import twb_pkg::*;
(
    input  wire logic         sys_clk_i,
    input  wire logic         resetn_i,
    input  wire twb_apb_req_t apb_i,
    output var  twb_apb_rsp_t apb_o,
    input  wire logic         scl_i,
    output logic              scl_o,
    output logic              scl_oe_o,
    input  wire logic         sda_i,
    output logic              sda_o,
    output logic              sda_oe_o,
    output logic              bus_irq_o
);
    // ************************************************
    // State and decode
    // ************************************************
    twb_state_t  st_reg;
    twb_state_t  st_next;
    logic [31:0] rd_word;
    logic        scl_h;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_det;
    logic        stop_det;
    logic        addr_ok;
    logic        wr_done;
    logic        ctrl_wr;
    logic        shift_wr;
    logic        rel_wr;
    logic        stt_wr;
    logic        spt_wr;
    logic        exit_wr;
    logic        tx_now;
    logic        next_bit;

    assign scl_h     = st_reg.scl_s2;
    assign scl_rise  = st_reg.scl_s2 & ~st_reg.scl_s3;
    assign scl_fall  = ~st_reg.scl_s2 & st_reg.scl_s3;
    assign start_det = scl_h & st_reg.scl_s3 & ~st_reg.sda_s2 & st_reg.sda_s3; // R01
    assign stop_det  = scl_h & st_reg.scl_s3 & st_reg.sda_s2 & ~st_reg.sda_s3; // R15
    assign addr_ok   = apb_i.paddr == OFS_CTRL || apb_i.paddr == OFS_STATUS
                    || apb_i.paddr == OFS_SHIFT || apb_i.paddr == OFS_ADDR;
    assign wr_done   = apb_i.psel & apb_i.penable & apb_i.pwrite & st_reg.rsp.pready
                     & addr_ok;
    assign ctrl_wr   = wr_done && apb_i.paddr == OFS_CTRL;
    assign shift_wr  = wr_done && apb_i.paddr == OFS_SHIFT;
    assign rel_wr    = ctrl_wr & apb_i.pwdata[CB_WREL];
    assign stt_wr    = ctrl_wr & apb_i.pwdata[CB_STT];
    assign spt_wr    = ctrl_wr & apb_i.pwdata[CB_SPT];
    assign exit_wr   = ctrl_wr & apb_i.pwdata[CB_EXIT];
    assign tx_now    = st_reg.is_addr ? st_reg.master : st_reg.trc;
    assign next_bit  = shift_wr ? apb_i.pwdata[7] : st_reg.shift[7];

    // ************************************************
    // Next state
    // ************************************************
    always_comb
    begin
        rd_word = '0;
        st_next = st_reg;
        // Pin synchronisers
        st_next.scl_s1 = scl_i;
        st_next.scl_s2 = st_reg.scl_s1;
        st_next.scl_s3 = st_reg.scl_s2;
        st_next.sda_s1 = sda_i;
        st_next.sda_s2 = st_reg.sda_s1;
        st_next.sda_s3 = st_reg.sda_s2;
        st_next.irq    = 1'h0;
        // Read mux
        unique case (apb_i.paddr)
            OFS_CTRL:
            begin
                rd_word[CB_EN]   = st_reg.en;
                rd_word[CB_ACKE] = st_reg.acke;
                rd_word[CB_WTIM] = st_reg.wtim;
                rd_word[CB_SPIE] = st_reg.spie;
            end
            OFS_STATUS:
            begin
                rd_word[SB_SPD]  = st_reg.spd;
                rd_word[SB_STD]  = st_reg.std;
                rd_word[SB_ACKD] = st_reg.ackd;
                rd_word[SB_TRC]  = st_reg.trc;
                rd_word[SB_MST]  = st_reg.master;
                rd_word[SB_SEL]  = st_reg.selected;
                rd_word[SB_WAIT] = st_reg.phase == PH_WAIT;
            end
            OFS_SHIFT: rd_word[7:0] = st_reg.shift;
            OFS_ADDR:  rd_word[7:0] = {st_reg.own_addr, 1'h0};
            default:   rd_word = '0;
        endcase
        // APB slave, one wait state
        st_next.rsp.pready  = 1'h0;
        st_next.rsp.pslverr = 1'h0;
        if (apb_i.psel && apb_i.penable && !st_reg.rsp.pready)
        begin
            st_next.rsp.pready  = 1'h1;
            st_next.rsp.pslverr = !addr_ok;
            st_next.rsp.prdata  = rd_word;
        end
        if (ctrl_wr)
        begin
            st_next.en   = apb_i.pwdata[CB_EN];
            st_next.acke = apb_i.pwdata[CB_ACKE];
            st_next.wtim = apb_i.pwdata[CB_WTIM];
            st_next.spie = apb_i.pwdata[CB_SPIE];
        end
        if (wr_done && apb_i.paddr == OFS_ADDR)
            st_next.own_addr = apb_i.pwdata[7:1];
        if (shift_wr)
            st_next.shift = apb_i.pwdata[7:0]; // R05
        // Condition flags
        if (start_det)
        begin
            st_next.std      = 1'h1; // R03
            st_next.spd      = 1'h0;
            st_next.ackd     = 1'h0;
            st_next.is_addr  = 1'h1;
            st_next.bit_cnt  = '0;
            st_next.selected = 1'h0;
        end
        if (stop_det)
        begin
            st_next.spd      = 1'h1; // R17
            st_next.std      = 1'h0;
            st_next.selected = 1'h0;
            st_next.irq      = st_reg.spie; // R17
        end
        // Sequencer
        unique case (st_reg.phase)
            PH_IDLE:
            begin
                st_next.scl_low = 1'h0;
                st_next.sda_low = 1'h0;
                st_next.master  = 1'h0;
                if (stt_wr && st_reg.spd && !start_det)
                begin
                    st_next.phase  = PH_START; // R02
                    st_next.master = 1'h1;
                    st_next.step   = ST_A;
                    st_next.div    = '0;
                end
            end
            PH_START:
            begin
                st_next.div = st_reg.div + 4'h1;
                if (st_reg.div == DIV_LAST)
                begin
                    st_next.div = '0;
                    unique case (st_reg.step)
                        ST_A:
                        begin
                            st_next.sda_low = 1'h0;
                            st_next.step    = ST_B;
                        end
                        ST_B:
                        begin
                            st_next.scl_low = 1'h0;
                            st_next.step    = ST_C;
                        end
                        ST_C:
                        begin
                            if (scl_h && st_reg.sda_s2)
                            begin
                                st_next.sda_low = 1'h1; // R01
                                st_next.step    = ST_D;
                            end
                        end
                        ST_D:
                        begin
                            st_next.scl_low  = 1'h1; // R19
                            st_next.phase    = PH_WAIT;
                            st_next.wait_ack = 1'h0;
                            st_next.is_addr  = 1'h1;
                            st_next.bit_cnt  = '0;
                        end
                    endcase
                end
            end
            PH_XFER:
            begin
                if (st_reg.master)
                begin
                    if (st_reg.scl_low || scl_h) // R18
                    begin
                        st_next.div = st_reg.div + 4'h1;
                        if (st_reg.div == DIV_LAST)
                        begin
                            st_next.div     = '0;
                            st_next.scl_low = !st_reg.scl_low;
                        end
                    end
                end
                if (scl_rise)
                begin
                    if (st_reg.bit_cnt == BIT_ACK)
                    begin
                        if (tx_now)
                            st_next.ackd = !st_reg.sda_s2; // R07 R08
                    end
                    else
                        st_next.shift = {st_reg.shift[6:0], st_reg.sda_s2}; // R05 R23
                    if (st_reg.is_addr && st_reg.bit_cnt == BIT_DIR)
                    begin
                        st_next.trc = st_reg.master ^ st_reg.sda_s2; // R06 R10
                        if (!st_reg.master)
                            st_next.selected = st_reg.shift[6:0] == st_reg.own_addr; // R04
                    end
                    st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
                end
                if (scl_fall)
                begin
                    if (st_reg.bit_cnt == BIT_ACK)
                    begin
                        if (st_reg.is_addr)
                            st_next.sda_low = !st_reg.master && st_reg.selected; // R12
                        else
                        begin
                            st_next.sda_low = !tx_now && st_reg.acke; // R07 R09 R11 R14
                            if (!st_reg.wtim)
                            begin
                                st_next.phase    = PH_WAIT; // R19
                                st_next.wait_ack = 1'h1;
                                st_next.scl_low  = 1'h1;
                            end
                        end
                    end
                    else if (st_reg.bit_cnt == BIT_END)
                    begin
                        st_next.bit_cnt = '0;
                        st_next.is_addr = 1'h0;
                        st_next.sda_low = st_reg.trc && !st_reg.shift[7];
                        if (!st_reg.master && !st_reg.selected)
                        begin
                            st_next.phase   = PH_IDLE;
                            st_next.sda_low = 1'h0;
                        end
                        else if (st_reg.is_addr || st_reg.wtim)
                        begin
                            st_next.phase    = PH_WAIT; // R19
                            st_next.wait_ack = 1'h0;
                            st_next.scl_low  = 1'h1;
                            st_next.sda_low  = 1'h0;
                        end
                    end
                    else
                        st_next.sda_low = tx_now && !st_reg.shift[7]; // R05
                end
                if (spt_wr && st_reg.master)
                begin
                    st_next.phase = PH_STOP; // R16
                    st_next.step  = ST_A;
                    st_next.div   = '0;
                end
            end
            PH_WAIT:
            begin
                st_next.scl_low = 1'h1;
                if (shift_wr || rel_wr)
                begin
                    st_next.phase = PH_XFER; // R20
                    st_next.div   = '0;
                    if (st_reg.wait_ack)
                        st_next.sda_low = !tx_now && st_reg.acke; // R13
                    else
                        st_next.sda_low = tx_now && !next_bit;
                    if (!st_reg.master)
                        st_next.scl_low = 1'h0;
                end
                else if (st_reg.master && (stt_wr || spt_wr))
                begin
                    st_next.phase = stt_wr ? PH_START : PH_STOP; // R20
                    st_next.step  = ST_A;
                    st_next.div   = '0;
                end
            end
            PH_STOP:
            begin
                st_next.div = st_reg.div + 4'h1;
                if (st_reg.div == DIV_LAST)
                begin
                    st_next.div = '0;
                    unique case (st_reg.step)
                        ST_A:
                        begin
                            st_next.scl_low = 1'h1;
                            st_next.step    = ST_B;
                        end
                        ST_B:
                        begin
                            st_next.sda_low = 1'h1;
                            st_next.step    = ST_C;
                        end
                        ST_C:
                        begin
                            st_next.scl_low = 1'h0;
                            st_next.step    = ST_D;
                        end
                        ST_D:
                        begin
                            if (scl_h)
                            begin
                                st_next.sda_low = 1'h0; // R15
                                st_next.phase   = PH_IDLE;
                            end
                        end
                    endcase
                end
            end
            default: st_next.phase = PH_IDLE;
        endcase
        // Slave follows bus conditions
        if (start_det && !st_reg.master)
        begin
            st_next.phase   = PH_XFER;
            st_next.scl_low = 1'h0;
            st_next.sda_low = 1'h0;
        end
        else if (stop_det && !st_reg.master)
        begin
            st_next.phase   = PH_IDLE;
            st_next.scl_low = 1'h0;
            st_next.sda_low = 1'h0;
        end
        if (exit_wr || !st_reg.en)
        begin
            st_next.phase    = PH_IDLE; // R22
            st_next.scl_low  = 1'h0;
            st_next.sda_low  = 1'h0;
            st_next.master   = 1'h0;
            st_next.selected = 1'h0;
            st_next.trc      = 1'h0;
            st_next.wait_ack = 1'h0;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
            st_reg <= ST_RST;
        else
            st_reg <= st_next;
    end

    // ************************************************
    // Outputs
    // ************************************************
    assign apb_o     = st_reg.rsp;
    assign scl_o     = 1'h0;
    assign sda_o     = 1'h0;
    assign scl_oe_o  = st_reg.scl_low; // R23
    assign sda_oe_o  = st_reg.sda_low; // R23
    assign bus_irq_o = st_reg.irq;

    // ************************************************
    // Assertions
    // ************************************************
    a_start_flag: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R03
        start_det |=> st_reg.std && !st_reg.spd)
        else $error("start not flagged");
    a_stop_flag: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R15
        stop_det |=> st_reg.spd && !st_reg.std)
        else $error("stop not flagged");
    a_irq_gate: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R17
        bus_irq_o |-> $past(stop_det) && $past(st_reg.spie))
        else $error("interrupt without enabled stop");
    a_wait_scl: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R19
        st_reg.phase == PH_WAIT |-> scl_oe_o)
        else $error("wait without clock held low");
    a_nack_foreign: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R12
        st_reg.phase == PH_XFER && st_reg.is_addr && !st_reg.master && !st_reg.selected
        && st_reg.bit_cnt == BIT_ACK |-> !sda_oe_o)
        else $error("foreign address acknowledged");
    a_exit_release: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R22
        exit_wr |=> st_reg.phase == PH_IDLE && !scl_oe_o && !sda_oe_o)
        else $error("exit did not release bus");
    a_trc_dir: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R10
        st_reg.phase == PH_XFER && st_reg.is_addr && !st_reg.master && scl_rise
        && st_reg.bit_cnt == BIT_DIR && st_reg.en && !exit_wr
        |=> st_reg.trc == $past(st_reg.sda_s2))
        else $error("transmit flag not from direction bit");
    a_start_gate: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R02
        st_reg.phase == PH_IDLE && stt_wr && !st_reg.spd && !start_det
        |=> st_reg.phase == PH_IDLE [*2])
        else $error("start driven without stop flag");
    a_master_stretch: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R18
        st_reg.master && st_reg.phase == PH_XFER && !st_reg.scl_low && !scl_h
        |=> !scl_oe_o)
        else $error("master pulled clock during stretch");
    a_release_ack: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R13
        st_reg.phase == PH_WAIT && st_reg.wait_ack && rel_wr && !exit_wr && st_reg.en
        && !start_det && !stop_det
        |=> sda_oe_o == (!$past(tx_now) && $past(st_reg.acke)))
        else $error("ack at release wrong");
endmodule : twb_engine
`default_nettype wire

// ==== verilog/twb_pkg.sv ====
`default_nettype none
package twb_pkg;
    // ************************************************
    // Register map and fields
    // ************************************************
    localparam int unsigned PADDR_W = 8;
    localparam logic [PADDR_W-1:0] OFS_CTRL   = 8'h00;
    localparam logic [PADDR_W-1:0] OFS_STATUS = 8'h04;
    localparam logic [PADDR_W-1:0] OFS_SHIFT  = 8'h08;
    localparam logic [PADDR_W-1:0] OFS_ADDR   = 8'h0C;
    localparam int CB_EN   = 0;
    localparam int CB_ACKE = 1;
    localparam int CB_WTIM = 2;
    localparam int CB_SPIE = 3;
    localparam int CB_WREL = 4;
    localparam int CB_STT  = 5;
    localparam int CB_SPT  = 6;
    localparam int CB_EXIT = 7;
    localparam int SB_SPD  = 0;
    localparam int SB_STD  = 1;
    localparam int SB_ACKD = 2;
    localparam int SB_TRC  = 3;
    localparam int SB_MST  = 4;
    localparam int SB_SEL  = 5;
    localparam int SB_WAIT = 6;
    localparam logic [3:0] BIT_DIR = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_END = 4'h9;
    // ************************************************
    // Timing
    // ************************************************
    localparam int SYS_CLK_PERIOD_NS = 100;
    localparam int SCL_HALF_NS       = 400;
    localparam int SCL_HALF_CYC      =
        (SCL_HALF_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam logic [3:0] DIV_LAST  = 4'(SCL_HALF_CYC - 1);
    // ************************************************
    // Types
    // ************************************************
    typedef enum logic [2:0] {PH_IDLE, PH_START, PH_XFER, PH_WAIT, PH_STOP} twb_phase_t;
    typedef enum logic [1:0] {ST_A, ST_B, ST_C, ST_D} twb_step_t;
    typedef struct packed {
        logic [PADDR_W-1:0] paddr;
        logic               psel;
        logic               penable;
        logic               pwrite;
        logic [31:0]        pwdata;
    } twb_apb_req_t;
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } twb_apb_rsp_t;
    typedef struct packed {
        logic         scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
        twb_phase_t   phase;
        twb_step_t    step;
        logic [3:0]   div;
        logic [3:0]   bit_cnt;
        logic [7:0]   shift;
        logic [6:0]   own_addr;
        logic         en, acke, wtim, spie;
        logic         master, selected, is_addr, trc, ackd, std, spd, wait_ack;
        logic         scl_low, sda_low, irq;
        twb_apb_rsp_t rsp;
    } twb_state_t;
    localparam twb_state_t ST_RST = '{phase: PH_IDLE, step: ST_A, spd: 1'h1, default: '0};
endpackage : twb_pkg
`default_nettype wire

// ==== sim/twb_peer.sv ====
`timescale 1ns/1ps
`default_nettype none
module twb_peer (
    input  wire logic  sys_clk_i,
    input  wire logic  scl_i,
    input  wire logic  sda_i,
    input  wire logic  ack_on_i,
    output logic       scl_low_o,
    output logic       sda_low_o,
    output logic [8:0] rx_o
);
    // ************************************************
    // Far-side master, auto-ack slave, bit capture
    // ************************************************
    logic       scl_drv = 1'h0, sda_drv = 1'h0, ack_low = 1'h0, sp = 1'h1, dp = 1'h1;
    logic [3:0] cnt     = 4'h0;
    assign scl_low_o = scl_drv;
    assign sda_low_o = sda_drv | ack_low;
    always @(posedge sys_clk_i)
    begin
        sp <= scl_i;
        dp <= sda_i;
        if (scl_i && sp && dp && !sda_i) cnt <= 4'h0;
        else if (scl_i && !sp)
        begin
            cnt  <= cnt + 4'h1;
            rx_o <= {rx_o[7:0], sda_i};
        end
        else if (!scl_i && sp) ack_low <= ack_on_i && cnt == 4'h8;
    end
    task automatic half();
        repeat (4) @(posedge sys_clk_i);
    endtask : half
    task automatic rise();
        scl_drv <= 1'h0;
        do @(posedge sys_clk_i); while (scl_i !== 1'h1);
        half();
    endtask : rise
    task automatic start();
        sda_drv <= 1'h1;
        half();
        scl_drv <= 1'h1;
        half();
    endtask : start
    task automatic stop();
        sda_drv <= 1'h1;
        half();
        rise();
        sda_drv <= 1'h0;
        half();
    endtask : stop
    task automatic send_byte(input logic [7:0] b, output logic a);
        for (int i = 8; i >= 0; i--)
        begin
            sda_drv <= (i > 0) ? !b[(i+7)%8] : 1'h0;
            half();
            rise();
            a = sda_i;
            scl_drv <= 1'h1;
        end
    endtask : send_byte
endmodule : twb_peer
`default_nettype wire

// ==== sim/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
    import twb_pkg::*;
    // ************************************************
    // Clock, open-drain wiring, instances
    // ************************************************
    logic         sys_clk_i = 1'h0, resetn_i = 1'h0, ack_on = 1'h0;
    twb_apb_req_t apb_i     = '0;
    twb_apb_rsp_t apb_o;
    logic         scl_oe, sda_oe, p_scl, p_sda, irq, ack, err, scl_d, sda_d;
    logic [8:0]   rx;
    logic [7:0]   adr, dat;
    logic [31:0]  rd, ctl, lf = 32'h5E71;
    int           n_errors = 0, n_checks = 0, irqs = 0, n0;
    wire logic    scl = !((scl_oe & !scl_d) | p_scl);
    wire logic    sda = !((sda_oe & !sda_d) | p_sda);
    always #50 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) if (irq === 1'h1) irqs++;
    twb_engine i_twb_engine (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .apb_i(apb_i),
        .apb_o(apb_o), .scl_i(scl), .scl_o(scl_d), .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(sda_d),
        .sda_oe_o(sda_oe), .bus_irq_o(irq));
    twb_peer i_twb_peer (.sys_clk_i(sys_clk_i), .scl_i(scl), .sda_i(sda), .ack_on_i(ack_on),
        .scl_low_o(p_scl), .sda_low_o(p_sda), .rx_o(rx));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        apb_i <= '{paddr: a, psel: 1'h1, penable: 1'h0, pwrite: w, pwdata: d};
        @(posedge sys_clk_i);
        apb_i.penable <= 1'h1;
        do @(posedge sys_clk_i); while (apb_o.pready !== 1'h1);
        rd = apb_o.prdata;
        err = apb_o.pslverr;
        apb_i <= '0;
    endtask : apb
    task automatic hold();
        repeat (4) @(posedge sys_clk_i);
        do apb(1'h0, OFS_STATUS, 32'h0); while (rd[SB_WAIT] !== 1'h1);
    endtask : hold
    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    // ************************************************
    // Sequence
    // ************************************************
    initial
    begin
        #4_000_000;
        n_errors++;
        final_report();
    end
    initial
    begin
        repeat (4) @(posedge sys_clk_i);
        resetn_i <= 1'h1;
        apb(1'h0, OFS_STATUS, 32'h0);
        chk(rd, 32'h1);
        apb(1'h1, 8'h10, 32'hFF);
        chk({rd[30:0], err}, 32'h1);
        for (int k = 0; k < 8; k++)
        begin
            lf  = lfsr(lf);
            adr = {lf[6:0], 1'h0};
            dat = lf[15:8];
            ctl = {28'h0, !k[1], k[0], !k[2], 1'h1};
            apb(1'h1, OFS_ADDR, {24'h0, adr});
            apb(1'h1, OFS_CTRL, ctl);
            i_twb_peer.start();
            apb(1'h0, OFS_STATUS, 32'h0);
            chk(rd[SB_STD], 1'h1);
            i_twb_peer.send_byte(adr ^ {6'h0, k[1], 1'h0}, ack);
            chk(ack, k[1]);
            apb(1'h0, OFS_STATUS, 32'h0);
            chk(rd[SB_SEL], !k[1]);
            if (!k[1])
            begin
                apb(1'h0, OFS_SHIFT, 32'h0);
                chk(rd, adr);
                fork
                    i_twb_peer.send_byte(dat, ack);
                    begin
                        apb(1'h1, OFS_CTRL, ctl | 32'h10);
                        if (!k[0]) hold();
                        if (!k[0]) apb(1'h1, OFS_CTRL, ctl | 32'h10);
                    end
                join
                chk(ack, k[2]);
                apb(1'h0, OFS_SHIFT, 32'h0);
                chk(rd, dat);
                if (k[0]) apb(1'h1, OFS_CTRL, ctl | 32'h10);
            end
            else
            begin
                apb(1'h1, OFS_CTRL, ctl | 32'h20);
                apb(1'h0, OFS_STATUS, 32'h0);
                chk(rd[SB_MST], 1'h0);
            end
            n0 = irqs;
            i_twb_peer.stop();
            repeat (8) @(posedge sys_clk_i);
            chk(irqs - n0, !k[1]);
            apb(1'h0, OFS_STATUS, 32'h0);
            chk(rd[SB_SPD], 1'h1);
        end
        ack_on <= 1'h1;
        for (int m = 0; m < 2; m++)
        begin
            lf  = lfsr(lf);
            adr = {lf[6:0], m[0]};
            apb(1'h1, OFS_CTRL, 32'h23);
            hold();
            chk(scl_oe, 1'h1);
            apb(1'h1, OFS_SHIFT, {24'h0, adr});
            hold();
            chk(rx[8:1], adr);
            chk(rd & 32'h5F, m ? 32'h56 : 32'h5E);
            if (m)
            begin
                apb(1'h1, OFS_CTRL, 32'h11);
                hold();
                chk(sda_oe, 1'h0);
                chk(rd[SB_TRC], 1'h0);
            end
            apb(1'h1, OFS_CTRL, m ? 32'h81 : 32'h43);
            repeat (30) @(posedge sys_clk_i);
            chk(scl_oe, 1'h0);
            if (m) i_twb_peer.stop();
            apb(1'h0, OFS_STATUS, 32'h0);
            chk(rd[SB_SPD], 1'h1);
        end
        final_report();
    end
endmodule : tb
`default_nettype wire
